// *** design/isl_cfg.svh ***
// register offsets, field positions and reset values of the latch block
`ifndef ISL_CFG_SVH
`define ISL_CFG_SVH
// register indices; byte address is four times the index
`define ISL_IDX_MODE_B   12'h022
`define ISL_IDX_STAT_A   12'h023
`define ISL_IDX_MODE_A   12'h030
`define ISL_IDX_STAT_B   12'h031
`define ISL_IDX_EVT_STAT 12'h032
`define ISL_IDX_EVT_CLR  12'h033
`define ISL_IDX_EVT_EN   12'h034
// implemented bits per register
`define ISL_MASK_B       8'hbf
`define ISL_MASK_A       8'hfe
`define ISL_MASK_EVT     16'hfebf
// reset values
`define ISL_RST_BYTE     8'h00
`define ISL_RST_EVT      16'h0000
`define ISL_RST_WORD     32'h00000000
// pair b field positions
`define ISL_B_PWR_ERR    7
`define ISL_B_BLANK      5
`define ISL_B_OSC_ALIGN  4
`define ISL_B_LOCKED     3
`define ISL_B_ROTATE     2
`define ISL_B_WINDOW     1
`define ISL_B_TRIPPED    0
// first status field positions
`define ISL_A_CAL_PASS   7
`define ISL_A_CAL_FAIL   6
`define ISL_A_CONV_LOST  5
`define ISL_A_CONV_LOCK  4
`define ISL_A_SER_LOST   3
`define ISL_A_SER_LOCK   2
`define ISL_A_LANE_ERR   1
`endif

// *** design/isl_latch_bank.sv ***
// eight status bits, each live or sticky as its latch-mode bit selects
`timescale 1ns/1ps
`include "isl_cfg.svh"
module isl_latch_bank
  import isl_pkg::*;
(
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      resetn,
  // conditions and mode
  input  wire isl_byte_t live,
  input  wire isl_byte_t mode,
  input  wire isl_byte_t mask,
  // write-one-to-clear
  input  wire logic      clr_we,
  input  wire isl_byte_t clr_data,
  // results
  output isl_byte_t      view,
  output isl_byte_t      held
);
  isl_byte_t prev;
  isl_byte_t next_held;

  // capture on rise while sticky; a rise in the clear cycle still sets
  always_comb begin
    next_held = held;
    if (clr_we) begin
      next_held = next_held & ~clr_data;
    end
    next_held = (next_held | isl_rise(live, prev)) & mode & mask;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prev <= `ISL_RST_BYTE;
      held <= `ISL_RST_BYTE;
    end else begin
      prev <= live;
      held <= next_held;
    end
  end

  // live bits where mode is low, captured bits where high
  assign view = ((held & mode) | (live & ~mode)) & mask;
endmodule

// *** design/isl_pkg.sv ***
// types and decode helpers shared by the latch block
package isl_pkg;
  typedef logic [7:0]  isl_byte_t;
  typedef logic [11:0] isl_addr_t;
  typedef logic [15:0] isl_evt_t;

  // byte address of a register index
  function automatic isl_addr_t isl_byte_addr(input isl_addr_t idx);
    return {idx[9:0], 2'b00};
  endfunction

  // rising edge of a vector against its previous sample
  function automatic isl_byte_t isl_rise(input isl_byte_t now, input isl_byte_t was);
    return now & ~was;
  endfunction
endpackage

// *** design/isl_sync.sv ***
// two-flop synchroniser for asynchronous status levels
`timescale 1ns/1ps
module isl_sync #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** design/isl_top.sv ***
// interrupt status latch block: pair b latch modes, first status register
`timescale 1ns/1ps
`include "isl_cfg.svh"

// How it works
// - mode bit 7 makes the pair b power-detect error sticky and pulls the pin low.
// - mode bit 5 makes pair b blanking-done sticky on its rise, else it reads live.
// - mode bit 4 makes the pair b oscillator-align flag sticky, else live.
// - mode bit 3 makes the pair b alignment-locked flag sticky on its rise, else live.
// - mode bit 2 makes the pair b alignment-rotate flag sticky, else live.
// - mode bit 1 makes the pair b outside-window flag sticky, else live.
// - mode bit 0 makes the pair b alignment-tripped flag sticky, else live.
// - a status bit is live while its mode bit is low, else captures on a rise.
// - a captured bit stays set until software writes 1 to it or clears its mode bit; writing 0 keeps it.
// - first status bit 7 reports calibration passed, live or sticky.
// - first status bit 6 reports calibration failed, live or sticky.
// - first status bit 5 reports converter pll lock lost, live or sticky.
// - first status bit 4 reports converter pll locked, live or sticky.
// - first status bit 3 reports serializer pll lock lost, live or sticky.
// - bit 2 reports serializer lock; bit 1 a lane buffer error held until link disable.
module isl_top
  import isl_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pair b conditions
  input  wire logic        power_detect_error_b,
  input  wire logic        blanking_done_b,
  input  wire logic        osc_align_tripped_b,
  input  wire logic        align_locked_b,
  input  wire logic        align_rotate_b,
  input  wire logic        align_outside_window_b,
  input  wire logic        align_tripped_b,
  // first status conditions
  input  wire logic        calibration_passed,
  input  wire logic        calibration_failed,
  input  wire logic        converter_pll_lost,
  input  wire logic        converter_pll_locked,
  input  wire logic        serializer_pll_lost,
  input  wire logic        serializer_pll_locked,
  input  wire logic        lane_buffer_error,
  input  wire logic        link_enable,
  // interrupt outputs
  output logic             irq_n,
  output logic             irq
);
  // synchronised conditions
  logic [15:0] cond_s;
  // lane error hold, cleared only by link disable
  logic        lane_hold;
  // live vectors
  isl_byte_t   live_b;
  isl_byte_t   live_a;
  // latch-mode registers
  isl_byte_t   latch_mode_pair_b;
  isl_byte_t   latch_mode_first;
  // bank results
  isl_byte_t   view_b;
  isl_byte_t   view_a;
  isl_byte_t   held_b;
  isl_byte_t   held_a;
  // event interrupt registers
  // evt_prev mirrors both live vectors to find rising edges
  isl_evt_t    evt_prev;
  isl_evt_t    evt_status;
  isl_evt_t    evt_enable;
  isl_evt_t    evt_rise;
  isl_evt_t    next_evt_status;
  // bus decode
  // one hit line per register, all from the same byte address
  logic        acc;
  logic        wr;
  logic        setup;
  logic        hit_mode_b;
  logic        hit_stat_a;
  logic        hit_mode_a;
  logic        hit_stat_b;
  logic        hit_evt_stat;
  logic        hit_evt_clr;
  logic        hit_evt_en;
  logic        mapped;
  logic        wr_lo;
  logic        wr_hi;
  logic [31:0] next_rdata;

  // every status source is asynchronous to ref_clk
  // link_enable rides in the top bit so its delay matches the lane error
  // bit 0 of the bundle is padding and is never read
  // a condition change reaches the banks one edge after it is first sampled
  // pulses shorter than one ref_clk period may be missed entirely
  // the synchroniser resets to zero, so no false edge follows reset
  isl_sync #(
    .W(16)
  ) u_sync (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in ({link_enable,
                power_detect_error_b,
                blanking_done_b,
                osc_align_tripped_b,
                align_locked_b,
                align_rotate_b,
                align_outside_window_b,
                align_tripped_b,
                calibration_passed,
                calibration_failed,
                converter_pll_lost,
                converter_pll_locked,
                serializer_pll_lost,
                serializer_pll_locked,
                lane_buffer_error,
                1'b0}),
    .sync_out (cond_s)
  );

  // lane error persists until the link is taken down
  // clear beats set here: while the link is down the buffers are idle,
  // so a stale error level must not survive the re-enable
  // the flag is a level, so a buffer error still standing re-sets it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lane_hold <= 1'b0;
    end else if (!cond_s[15]) begin
      lane_hold <= 1'b0;
    end else if (cond_s[1]) begin
      lane_hold <= 1'b1;
    end
  end

  // pair b live vector, bit 6 reserved
  // reserved positions stay at the reset value so they read zero
  always_comb begin
    live_b                   = `ISL_RST_BYTE;
    live_b[`ISL_B_PWR_ERR]   = cond_s[14];
    live_b[`ISL_B_BLANK]     = cond_s[13];
    live_b[`ISL_B_OSC_ALIGN] = cond_s[12];
    live_b[`ISL_B_LOCKED]    = cond_s[11];
    live_b[`ISL_B_ROTATE]    = cond_s[10];
    live_b[`ISL_B_WINDOW]    = cond_s[9];
    live_b[`ISL_B_TRIPPED]   = cond_s[8];
  end

  // first status live vector, bit 0 reserved
  // the lane bit shows the held level, not the raw pin
  always_comb begin
    live_a                   = `ISL_RST_BYTE;
    live_a[`ISL_A_CAL_PASS]  = cond_s[7];
    live_a[`ISL_A_CAL_FAIL]  = cond_s[6];
    live_a[`ISL_A_CONV_LOST] = cond_s[5];
    live_a[`ISL_A_CONV_LOCK] = cond_s[4];
    live_a[`ISL_A_SER_LOST]  = cond_s[3];
    live_a[`ISL_A_SER_LOCK]  = cond_s[2];
    live_a[`ISL_A_LANE_ERR]  = lane_hold;
  end

  // apb decode; a write lands only at the access edge
  // pready is high only in the access cycle, so acc marks the one
  // edge at which a transfer completes; pslverr blocks unmapped writes
  // pstrb[0] and pstrb[1] gate the two low eight-bit lanes of the data word; the upper lanes are unused
  // setup is a single cycle; pready answers it with no wait states
  assign setup        = psel & ~penable;
  assign acc          = psel & penable & pready;
  assign wr           = acc & pwrite & ~pslverr;
  assign wr_lo        = wr & pstrb[0];
  assign wr_hi        = wr & pstrb[1];
  assign hit_mode_b   = (paddr == isl_byte_addr(`ISL_IDX_MODE_B));
  assign hit_stat_a   = (paddr == isl_byte_addr(`ISL_IDX_STAT_A));
  assign hit_mode_a   = (paddr == isl_byte_addr(`ISL_IDX_MODE_A));
  assign hit_stat_b   = (paddr == isl_byte_addr(`ISL_IDX_STAT_B));
  assign hit_evt_stat = (paddr == isl_byte_addr(`ISL_IDX_EVT_STAT));
  assign hit_evt_clr  = (paddr == isl_byte_addr(`ISL_IDX_EVT_CLR));
  assign hit_evt_en   = (paddr == isl_byte_addr(`ISL_IDX_EVT_EN));
  assign mapped       = hit_mode_b | hit_stat_a | hit_mode_a | hit_stat_b
                      | hit_evt_stat | hit_evt_clr | hit_evt_en;

  // latch-mode registers steer the two banks
  // reserved mode bits are masked on write so they always read zero
  // clearing a mode bit also drops its held bit in the bank
  // both mode registers use only byte lane 0
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      latch_mode_pair_b <= `ISL_RST_BYTE;
      latch_mode_first  <= `ISL_RST_BYTE;
    end else begin
      if (wr_lo && hit_mode_b) begin
        latch_mode_pair_b <= pwdata[7:0] & `ISL_MASK_B;
      end
      if (wr_lo && hit_mode_a) begin
        latch_mode_first <= pwdata[7:0] & `ISL_MASK_A;
      end
    end
  end

  // pair b bank: live or sticky per bit
  // both banks share one write data lane; only the decoded one clears
  // view is what software reads, held drives the pin
  isl_latch_bank u_bank_b (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .live     (live_b),
    .mode     (latch_mode_pair_b),
    .mask     (`ISL_MASK_B),
    .clr_we   (wr_lo & hit_stat_b),
    .clr_data (pwdata[7:0]),
    .view     (view_b),
    .held     (held_b)
  );

  // first status bank: live or sticky per bit
  // the lane bit gets the same sticky choice as the others
  isl_latch_bank u_bank_a (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .live     (live_a),
    .mode     (latch_mode_first),
    .mask     (`ISL_MASK_A),
    .clr_we   (wr_lo & hit_stat_a),
    .clr_data (pwdata[7:0]),
    .view     (view_a),
    .held     (held_a)
  );

  // event interrupt: every rising condition is recorded here
  // this path ignores the latch modes, so software sees every edge
  // even for bits that are shown live in the status registers
  // bits 8 and 6 of the event word are reserved and never set
  assign evt_rise = {live_a, live_b} & ~evt_prev & `ISL_MASK_EVT;

  // set wins over a clear written in the same cycle
  // losing an edge would hide an event, a spare set only costs a read
  always_comb begin
    next_evt_status = evt_status;
    if (hit_evt_clr && wr_lo) begin
      next_evt_status[7:0] = next_evt_status[7:0] & ~pwdata[7:0];
    end
    if (hit_evt_clr && wr_hi) begin
      next_evt_status[15:8] = next_evt_status[15:8] & ~pwdata[15:8];
    end
    next_evt_status = next_evt_status | evt_rise;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      evt_prev   <= `ISL_RST_EVT;
      evt_status <= `ISL_RST_EVT;
    end else begin
      evt_prev   <= {live_a, live_b};
      evt_status <= next_evt_status;
    end
  end

  // enable register, byte lanes honoured
  // reserved enable bits are masked so they cannot raise irq
  // the low byte uses the pair b mask, the high byte the first one
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      evt_enable <= `ISL_RST_EVT;
    end else begin
      if (wr_lo && hit_evt_en) begin
        evt_enable[7:0] <= pwdata[7:0] & `ISL_MASK_B;
      end
      if (wr_hi && hit_evt_en) begin
        evt_enable[15:8] <= pwdata[15:8] & `ISL_MASK_A;
      end
    end
  end

  // read mux; write-only clear register reads zero
  // at most one hit is true, so the order of the tests does not matter
  // unmapped addresses fall through to zero
  // the event registers are sixteen bits wide, the rest eight
  always_comb begin
    next_rdata = `ISL_RST_WORD;
    if (hit_mode_b) begin
      next_rdata[7:0] = latch_mode_pair_b;
    end
    if (hit_mode_a) begin
      next_rdata[7:0] = latch_mode_first;
    end
    if (hit_stat_a) begin
      next_rdata[7:0] = view_a;
    end
    if (hit_stat_b) begin
      next_rdata[7:0] = view_b;
    end
    if (hit_evt_stat) begin
      next_rdata[15:0] = evt_status;
    end
    if (hit_evt_en) begin
      next_rdata[15:0] = evt_enable;
    end
  end

  // one wait-free answer: pready rises the cycle after setup
  // data is frozen with pready so a slow master sees stable values
  // read data is taken at the setup edge, one cycle before the master
  // samples it; a status change in between shows on the next read
  // prdata returns to zero after the access so stale data never lingers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ISL_RST_WORD;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? `ISL_RST_WORD : next_rdata;
      end else if (acc) begin
        prdata <= `ISL_RST_WORD;
      end
    end
  end

  // pin stays low until every captured bit is cleared
  // the held vectors already include this cycle's set-over-clear
  // the pin follows held bits only; live bits never pull it low
  // one edge of delay after the held vector, so a clear shows next cycle
  // reset leaves the pin released, high
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~(|held_a | |held_b);
    end
  end

  // level output, high while an enabled event is pending
  // uses the next status so the level rises with the recorded event
  // the enable register alone decides, the latch modes play no part
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_evt_status & evt_enable);
    end
  end
endmodule

// *** tb/irq_status_latch_dual_b_bench.sv ***
// self-checking bench for the interrupt status latch block
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module irq_status_latch_dual_b_bench;
  localparam logic [15:0] M16 = 16'hfebf;
  logic        ref_clk, resetn, psel, penable, pwrite, link_enable, ack;
  logic        pready, pslverr, irq_n, irq, pending;
  logic [11:0] paddr, s;
  logic [31:0] pwdata, prdata, rnd, v;
  logic [3:0]  pstrb;
  logic [15:0] cond;
  logic [32:0] expq[$];
  logic [32:0] exp_v;
  logic [11:0] addrs[7] = '{12'h088, 12'h08c, 12'h0c0, 12'h0c4, 12'h0c8, 12'h0cc, 12'h0d0};
  int          num_errors, compares, cycles;

  isl_top u_isl_top (
    .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_detect_error_b(cond[7]), .blanking_done_b(cond[5]),
    .osc_align_tripped_b(cond[4]), .align_locked_b(cond[3]), .align_rotate_b(cond[2]),
    .align_outside_window_b(cond[1]), .align_tripped_b(cond[0]),
    .calibration_passed(cond[15]), .calibration_failed(cond[14]),
    .converter_pll_lost(cond[13]), .converter_pll_locked(cond[12]),
    .serializer_pll_lost(cond[11]), .serializer_pll_locked(cond[10]),
    .lane_buffer_error(cond[9]), .link_enable(link_enable), .irq_n(irq_n), .irq(irq)
  );
  isl_host_model u_isl_host_model (
    .ref_clk(ref_clk), .resetn(resetn), .irq_n(irq_n), .ack(ack), .pending(pending)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("Checks %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, well above the fewer than 500 cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // read answers are matched in order against the driver's notes
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : 33'bx;
      `CHK("read", exp_v, {pslverr, prdata})
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    if (!w) expq.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0, {1'b0, e});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    cond = 16'h0000;
    link_enable = 1'b1;
    ack = 1'b0;
    rnd = 32'h6505;
    tick(4);
    resetn <= 1'b1;
    tick(3);
    foreach (addrs[i]) rd(addrs[i], 32'h0);
    apb(12'h0fc, 1'b0, 32'h0, {1'b1, 32'h0});
    wr(12'h088, 32'hff);
    rd(12'h088, 32'hbf);
    wr(12'h0c0, 32'hff);
    rd(12'h0c0, 32'hfe);
    wr(12'h088, 32'h0);
    wr(12'h0c0, 32'h0);
    // live view of random conditions; lane bit left out since it holds
    repeat (8) begin
      rnd = lfsr(rnd);
      cond <= rnd[15:0] & 16'hfcbf;
      tick(4);
      rd(12'h0c4, {24'h0, rnd[7:0] & 8'hbf});
      rd(12'h08c, {24'h0, rnd[15:8] & 8'hfc});
      `CHK("irq_n", 1'b1, irq_n)
    end
    cond <= 16'h0000;
    wr(12'h088, 32'hbf);
    wr(12'h0c0, 32'hfe);
    // each bit sticky: capture, survive a zero write, clear with a one
    for (int b = 0; b < 16; b++) begin
      if (M16[b]) begin
        s = (b < 8) ? 12'h0c4 : 12'h08c;
        v = {24'h0, 8'h01 << b[2:0]};
        cond[b] <= 1'b1;
        tick(2);
        cond[b] <= 1'b0;
        link_enable <= 1'b0;
        tick(6);
        link_enable <= 1'b1;
        `CHK("irq_n", 1'b0, irq_n)
        `CHK("pending", 1'b1, pending)
        ack <= 1'b1;
        wr(s, 32'h0);
        rd(s, v);
        wr(s, v);
        ack <= 1'b0;
        rd(s, 32'h0);
        `CHK("irq_n", 1'b1, irq_n)
      end
    end
    // two captured bits: pin held until both are cleared
    cond <= 16'h0003;
    tick(8);
    cond <= 16'h0000;
    wr(12'h0c4, 32'h1);
    tick(2);
    `CHK("irq_n", 1'b0, irq_n)
    wr(12'h0c4, 32'h2);
    tick(2);
    `CHK("irq_n", 1'b1, irq_n)
    // event interrupt: record, enable, mask, clear
    rd(12'h0c8, 32'h0000febf);
    wr(12'h0d0, 32'h1);
    tick(2);
    `CHK("irq", 1'b1, irq)
    wr(12'h0d0, 32'h0);
    tick(2);
    `CHK("irq", 1'b0, irq)
    wr(12'h0d0, 32'h1);
    wr(12'h0c8, 32'h0);
    wr(12'h0cc, 32'hffff);
    tick(2);
    `CHK("irq", 1'b0, irq)
    rd(12'h0c8, 32'h0);
    rd(12'h0cc, 32'h0);
    // lane error shown live holds until the link goes down
    wr(12'h0c0, 32'h0);
    cond[9] <= 1'b1;
    tick(2);
    cond[9] <= 1'b0;
    tick(6);
    rd(12'h08c, 32'h2);
    link_enable <= 1'b0;
    tick(4);
    link_enable <= 1'b1;
    tick(4);
    rd(12'h08c, 32'h0);
    `CHK("queue", 0, expq.size())
    final_report();
  end
endmodule

// *** tb/isl_host_model.sv ***
// host side model: notes the active-low interrupt until serviced
`timescale 1ns/1ps
module isl_host_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // interrupt and service
  input  wire logic irq_n,
  input  wire logic ack,
  output logic      pending
);
  // request stays noted until software raises ack; ack wins over a pin that is still low
  always_ff @(posedge ref_clk) begin
    if (!resetn || ack) begin
      pending <= 1'b0;
    end else if (!irq_n) begin
      pending <= 1'b1;
    end
  end
endmodule

// *** tb/isl_top_sva.sv ***
// concurrent checks on the latch block's ports
`timescale 1ns/1ps
module isl_top_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // apb
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // condition and interrupts
  input wire logic        power_detect_error_b,
  input wire logic        irq_n,
  input wire logic        irq
);
  logic [7:0]  mode_b_q, mode_a_q;
  logic [15:0] en_q;
  logic        wr_acc, mapped;
  // access decode; mapped list mirrors the register map
  assign wr_acc = psel && penable && pready && pwrite;
  assign mapped = paddr inside {12'h088, 12'h08c, 12'h0c0, 12'h0c4, 12'h0c8, 12'h0cc, 12'h0d0};
  // shadow of mode and enable registers, so no peeking inside the design
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_b_q <= 8'h00;
      mode_a_q <= 8'h00;
      en_q     <= 16'h0000;
    end else if (wr_acc) begin
      if (paddr == 12'h088 && pstrb[0]) mode_b_q <= pwdata[7:0] & 8'hbf;
      if (paddr == 12'h0c0 && pstrb[0]) mode_a_q <= pwdata[7:0] & 8'hfe;
      if (paddr == 12'h0d0 && pstrb[0]) en_q[7:0] <= pwdata[7:0] & 8'hbf;
      if (paddr == 12'h0d0 && pstrb[1]) en_q[15:8] <= pwdata[15:8] & 8'hfe;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  reset_quiet_a: assert property ($past(!resetn) |-> irq_n && !irq && !pready)
    else $error("outputs not idle after reset");
  rsv_mode_zero_a: assert property (pready && psel && !pwrite && paddr == 12'h088
    |-> prdata[31:8] == 24'h0 && !prdata[6]) else $error("reserved mode bits not zero");
  pwr_err_irq_a: assert property ($rose(power_detect_error_b) && mode_b_q[7] ##1
    mode_b_q[7] [*3] |=> ##[0:2] !irq_n) else $error("captured error did not pull pin low");
  live_no_irq_a: assert property ((mode_b_q == 8'h00 && mode_a_q == 8'h00) [*3] |-> irq_n)
    else $error("pin low with every bit in live mode");
  fall_needs_mode_a: assert property ($fell(irq_n) |-> (mode_b_q | mode_a_q) != 8'h00)
    else $error("pin fell with no sticky bit selected");
  irq_masked_a: assert property ((en_q == 16'h0000) [*2] |-> !irq)
    else $error("event interrupt high while all disabled");
  w1c_zero_keep_a: assert property (wr_acc && (paddr == 12'h08c || paddr == 12'h0c4)
    && pwdata[7:0] == 8'h00 && !irq_n |=> !irq_n) else $error("zero write released pin");
  ready_decode_a: assert property (psel && !penable
    |=> pready && (pslverr == !$past(mapped))) else $error("bad answer to setup");
  cover property (!irq_n);
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property (wr_acc && paddr == 12'h08c);
endmodule

bind isl_top isl_top_sva u_isl_top_sva (
  .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .power_detect_error_b(power_detect_error_b), .irq_n(irq_n), .irq(irq)
);
